// ---- common/clkrst_pkg.sv ----
// Shared constants for the deep-sleep gating and soft-reset block.
// Assumes a 32-bit AXI4-Lite register port with 12-bit byte addresses.
package clkrst_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int NUM_PORTS = 8;
    localparam int SEL_W = 3;

    localparam logic [11:0] OFF_SOFT_RESET = 12'h040;
    localparam logic [11:0] OFF_RUN_CFG = 12'h060;
    localparam logic [11:0] OFF_RUN_GATE = 12'h100;
    localparam logic [11:0] OFF_SLEEP_GATE = 12'h110;
    localparam logic [11:0] OFF_DEEP_GATE = 12'h128;
    localparam logic [11:0] OFF_INT_STATUS = 12'h180;
    localparam logic [11:0] OFF_INT_MASK = 12'h184;

    localparam logic [31:0] REG_RESET = 32'h0000_0000;
    localparam logic [31:0] GATE_MASK = 32'h0000_00FF;
    localparam logic [31:0] SRST_MASK = 32'h0001_0048;
    localparam logic [31:0] RUN_CFG_MASK = 32'h0800_0000;
    localparam logic [31:0] INT_MASK_W = 32'h0000_0003;

    localparam int SRST_ADC0_BIT = 16;
    localparam int SRST_HIB_BIT = 6;
    localparam int SRST_WDOG_BIT = 3;
    localparam int ACG_BIT = 27;
    localparam int INT_FAULT_BIT = 0;
    localparam int INT_MASKED_BIT = 1;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0]
    {
        MODE_RUN,
        MODE_SLEEP,
        MODE_DEEP
    } power_mode_t;

endpackage

// ---- logic/access_check.sv ----
// Flags port accesses that hit a port whose clock is gated off.
// Assumes one access request per cycle from same-clock bus logic.
`timescale 1ns/100ps
module access_check
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic acc_valid,
    input wire logic [2:0] acc_sel,
    input wire logic [7:0] clk_en,
    output logic fault
);

    logic fault_r;
    logic fault_nxt;

    assign fault_nxt = acc_valid && !clk_en[acc_sel];
    assign fault = fault_r;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            fault_r <= 1'b0;
        else
            fault_r <= fault_nxt;
    end

endmodule // access_check

// ---- logic/clock_gate_ctl.sv ----
// Deep-sleep port clock gating and peripheral soft-reset control.
// Assumes an AXI4-Lite master on aclk; power_mode, cap_mask and the
// port access request come from logic on the same clock.
//
// Notes on behaviour
// - The deep-sleep gate register has one enable per port, A at bit 0 to H at bit 7.
// - A port whose active gate bit is 1 gets its clock, at 0 it is unclocked.
// - An access to a port whose clock is gated off answers with a bus fault.
// - All gate enables come out of reset at 0, so every port starts unclocked.
// - Run, sleep and deep-sleep gate registers are chosen by the power state.
// - Sleep and deep-sleep sets apply only when automatic gating is on.
// - Bits 31:8 of the deep-sleep gate register are read-only zero.
// - Soft-reset writes are masked by the capability bits.
// - Soft-reset bit 16 holds the converter module 0 in reset.
// - Soft-reset bit 6 holds the hibernation module in reset.
// - Soft-reset bit 3 holds the watchdog in reset; other bits read zero.
// - The deep-sleep gate and soft-reset registers reset to all zero.
`timescale 1ns/100ps
module clock_gate_ctl
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [11:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire clkrst_pkg::power_mode_t power_mode,
    input wire logic [31:0] capability_mask_1,
    input wire logic port_acc_valid,
    input wire logic [2:0] port_acc_sel,
    output logic port_acc_fault,
    output logic [7:0] port_clk_en,
    output logic adc0_reset,
    output logic hibernate_reset_ctl,
    output logic watchdog_reset_ctl,
    output logic irq
);

    // Word match on the register index; byte lanes come from wstrb
    function automatic logic hit
    (
        input logic [11:0] addr,
        input logic [11:0] off
    );
        hit = (addr[11:2] == off[11:2]);
    endfunction

    // Byte-lane merge limited to the writable field bits
    function automatic logic [31:0] merge
    (
        input logic [31:0] old,
        input logic [31:0] data,
        input logic [3:0] strb,
        input logic [31:0] field
    );
        logic [31:0] lanes;
        lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        merge = ((old & ~lanes) | (data & lanes)) & field;
    endfunction

    // Bus channel state
    logic awready_r;
    logic wready_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic arready_r;
    logic rvalid_r;
    logic [1:0] rresp_r;
    logic [31:0] rdata_r;
    logic [11:0] wr_addr_r;
    logic [31:0] wr_data_r;
    logic [3:0] wr_strb_r;

    // Register file
    logic [31:0] periph_soft_reset_0_r;
    logic [31:0] run_clock_config_r;
    logic [31:0] run_clock_gate_2_r;
    logic [31:0] sleep_clock_gate_2_r;
    logic [31:0] deep_sleep_clock_gate_2_r;
    logic [31:0] int_status_r;
    logic [31:0] int_mask_r;

    // Output flops
    logic [7:0] port_clk_en_r;
    logic adc0_reset_r;
    logic hibernate_reset_ctl_r;
    logic watchdog_reset_ctl_r;
    logic irq_r;

    logic aw_take;
    logic w_take;
    logic wr_fire;
    logic wr_done;
    logic ar_take;
    logic rd_done;

    logic wr_srst;
    logic wr_cfg;
    logic wr_run;
    logic wr_sleep;
    logic wr_deep;
    logic wr_stat;
    logic wr_mask;
    logic wr_ok;

    logic rd_srst;
    logic rd_cfg;
    logic rd_run;
    logic rd_sleep;
    logic rd_deep;
    logic rd_stat;
    logic rd_mask;
    logic rd_ok;
    logic [31:0] rd_word;

    logic [31:0] srst_field;
    logic [31:0] srst_refused;
    logic [31:0] periph_soft_reset_0_nxt;
    logic [31:0] run_clock_config_nxt;
    logic [31:0] run_clock_gate_2_nxt;
    logic [31:0] sleep_clock_gate_2_nxt;
    logic [31:0] deep_sleep_clock_gate_2_nxt;
    logic [31:0] int_mask_nxt;
    logic [31:0] int_status_nxt;
    logic [31:0] int_events;
    logic [31:0] int_kept;
    logic [7:0] port_clk_en_nxt;
    logic fault_pulse;

    // Channel handshakes; address and data may arrive in either order
    assign aw_take = awvalid && awready_r;
    assign w_take = wvalid && wready_r;
    assign wr_fire = !awready_r && !wready_r && !bvalid_r;
    assign wr_done = bvalid_r && bready;
    assign ar_take = arvalid && arready_r;
    assign rd_done = rvalid_r && rready;

    // Write decode
    assign wr_srst = wr_fire && hit(wr_addr_r, clkrst_pkg::OFF_SOFT_RESET);
    assign wr_cfg = wr_fire && hit(wr_addr_r, clkrst_pkg::OFF_RUN_CFG);
    assign wr_run = wr_fire && hit(wr_addr_r, clkrst_pkg::OFF_RUN_GATE);
    assign wr_sleep = wr_fire
        && hit(wr_addr_r, clkrst_pkg::OFF_SLEEP_GATE);
    assign wr_deep = wr_fire && hit(wr_addr_r, clkrst_pkg::OFF_DEEP_GATE);
    assign wr_stat = wr_fire
        && hit(wr_addr_r, clkrst_pkg::OFF_INT_STATUS);
    assign wr_mask = wr_fire && hit(wr_addr_r, clkrst_pkg::OFF_INT_MASK);
    assign wr_ok = wr_srst || wr_cfg || wr_run || wr_sleep || wr_deep
        || wr_stat || wr_mask;

    // Read decode
    assign rd_srst = hit(araddr, clkrst_pkg::OFF_SOFT_RESET);
    assign rd_cfg = hit(araddr, clkrst_pkg::OFF_RUN_CFG);
    assign rd_run = hit(araddr, clkrst_pkg::OFF_RUN_GATE);
    assign rd_sleep = hit(araddr, clkrst_pkg::OFF_SLEEP_GATE);
    assign rd_deep = hit(araddr, clkrst_pkg::OFF_DEEP_GATE);
    assign rd_stat = hit(araddr, clkrst_pkg::OFF_INT_STATUS);
    assign rd_mask = hit(araddr, clkrst_pkg::OFF_INT_MASK);
    assign rd_ok = rd_srst || rd_cfg || rd_run || rd_sleep || rd_deep
        || rd_stat || rd_mask;

    // Unmapped reads return zero with an error response
    assign rd_word = rd_srst ? periph_soft_reset_0_r
        : rd_cfg ? run_clock_config_r
        : rd_run ? run_clock_gate_2_r
        : rd_sleep ? sleep_clock_gate_2_r
        : rd_deep ? deep_sleep_clock_gate_2_r
        : rd_stat ? int_status_r
        : rd_mask ? int_mask_r
        : clkrst_pkg::REG_RESET;

    // Capability bits gate which reset controls may ever be set
    assign srst_field = clkrst_pkg::SRST_MASK & capability_mask_1;
    assign srst_refused = wr_data_r & clkrst_pkg::SRST_MASK
        & ~capability_mask_1
        & merge(clkrst_pkg::REG_RESET, 32'hFFFF_FFFF, wr_strb_r,
                32'hFFFF_FFFF);

    assign periph_soft_reset_0_nxt = wr_srst
        ? merge(periph_soft_reset_0_r, wr_data_r, wr_strb_r,
                srst_field)
        : periph_soft_reset_0_r;
    assign run_clock_config_nxt = wr_cfg
        ? merge(run_clock_config_r, wr_data_r, wr_strb_r,
                clkrst_pkg::RUN_CFG_MASK)
        : run_clock_config_r;
    assign run_clock_gate_2_nxt = wr_run
        ? merge(run_clock_gate_2_r, wr_data_r, wr_strb_r,
                clkrst_pkg::GATE_MASK)
        : run_clock_gate_2_r;
    assign sleep_clock_gate_2_nxt = wr_sleep
        ? merge(sleep_clock_gate_2_r, wr_data_r, wr_strb_r,
                clkrst_pkg::GATE_MASK)
        : sleep_clock_gate_2_r;
    // Upper bits never stored, so they read back as zero
    assign deep_sleep_clock_gate_2_nxt = wr_deep
        ? merge(deep_sleep_clock_gate_2_r, wr_data_r, wr_strb_r,
                clkrst_pkg::GATE_MASK)
        : deep_sleep_clock_gate_2_r;
    assign int_mask_nxt = wr_mask
        ? merge(int_mask_r, wr_data_r, wr_strb_r, clkrst_pkg::INT_MASK_W)
        : int_mask_r;

    // Sticky events; a new event in the clearing read's cycle survives
    assign int_events[clkrst_pkg::INT_FAULT_BIT] = fault_pulse;
    assign int_events[clkrst_pkg::INT_MASKED_BIT] = wr_srst
        && (srst_refused != clkrst_pkg::REG_RESET);
    assign int_events[31:2] = '0;
    assign int_kept = (ar_take && rd_stat)
        ? clkrst_pkg::REG_RESET : int_status_r;
    assign int_status_nxt = int_kept | int_events;

    gate_select u_gate_select
    (
        .mode(power_mode),
        .auto_clock_gating(run_clock_config_r[clkrst_pkg::ACG_BIT]),
        .run_clock_gate_2(run_clock_gate_2_r[7:0]),
        .sleep_clock_gate_2(sleep_clock_gate_2_r[7:0]),
        .deep_sleep_clock_gate_2(deep_sleep_clock_gate_2_r[7:0]),
        .port_en(port_clk_en_nxt)
    );

    // Checked against the clock actually delivered this cycle
    access_check u_access_check
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .acc_valid(port_acc_valid),
        .acc_sel(port_acc_sel),
        .clk_en(port_clk_en_r),
        .fault(fault_pulse)
    );

    // Write address and data channels
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            wr_addr_r <= '0;
            wr_data_r <= clkrst_pkg::REG_RESET;
            wr_strb_r <= '0;
        end
        else
        begin
            if (aw_take)
            begin
                awready_r <= 1'b0;
                wr_addr_r <= awaddr;
            end
            else if (wr_done)
                awready_r <= 1'b1;
            if (w_take)
            begin
                wready_r <= 1'b0;
                wr_data_r <= wdata;
                wr_strb_r <= wstrb;
            end
            else if (wr_done)
                wready_r <= 1'b1;
        end
    end

    // Write response
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_r <= 1'b0;
            bresp_r <= clkrst_pkg::RESP_OKAY;
        end
        else if (wr_fire)
        begin
            bvalid_r <= 1'b1;
            bresp_r <= wr_ok ? clkrst_pkg::RESP_OKAY
                : clkrst_pkg::RESP_SLVERR;
        end
        else if (wr_done)
            bvalid_r <= 1'b0;
    end

    // Read channels; data is captured when the address is taken
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rresp_r <= clkrst_pkg::RESP_OKAY;
            rdata_r <= clkrst_pkg::REG_RESET;
        end
        else if (ar_take)
        begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rdata_r <= rd_word;
            rresp_r <= rd_ok ? clkrst_pkg::RESP_OKAY
                : clkrst_pkg::RESP_SLVERR;
        end
        else if (rd_done)
        begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
        end
    end

    // Register file
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            periph_soft_reset_0_r <= clkrst_pkg::REG_RESET;
            run_clock_config_r <= clkrst_pkg::REG_RESET;
            run_clock_gate_2_r <= clkrst_pkg::REG_RESET;
            sleep_clock_gate_2_r <= clkrst_pkg::REG_RESET;
            deep_sleep_clock_gate_2_r <= clkrst_pkg::REG_RESET;
            int_status_r <= clkrst_pkg::REG_RESET;
            int_mask_r <= clkrst_pkg::REG_RESET;
        end
        else
        begin
            periph_soft_reset_0_r <= periph_soft_reset_0_nxt;
            run_clock_config_r <= run_clock_config_nxt;
            run_clock_gate_2_r <= run_clock_gate_2_nxt;
            sleep_clock_gate_2_r <= sleep_clock_gate_2_nxt;
            deep_sleep_clock_gate_2_r <= deep_sleep_clock_gate_2_nxt;
            int_status_r <= int_status_nxt;
            int_mask_r <= int_mask_nxt;
        end
    end

    // Clock enables, reset holds and interrupt line
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            port_clk_en_r <= '0;
            adc0_reset_r <= 1'b0;
            hibernate_reset_ctl_r <= 1'b0;
            watchdog_reset_ctl_r <= 1'b0;
            irq_r <= 1'b0;
        end
        else
        begin
            port_clk_en_r <= port_clk_en_nxt;
            adc0_reset_r <=
                periph_soft_reset_0_r[clkrst_pkg::SRST_ADC0_BIT];
            hibernate_reset_ctl_r <=
                periph_soft_reset_0_r[clkrst_pkg::SRST_HIB_BIT];
            watchdog_reset_ctl_r <=
                periph_soft_reset_0_r[clkrst_pkg::SRST_WDOG_BIT];
            irq_r <= |(int_status_r & int_mask_r);
        end
    end

    assign awready = awready_r;
    assign wready = wready_r;
    assign bvalid = bvalid_r;
    assign bresp = bresp_r;
    assign arready = arready_r;
    assign rvalid = rvalid_r;
    assign rresp = rresp_r;
    assign rdata = rdata_r;
    assign port_clk_en = port_clk_en_r;
    assign port_acc_fault = fault_pulse;
    assign adc0_reset = adc0_reset_r;
    assign hibernate_reset_ctl = hibernate_reset_ctl_r;
    assign watchdog_reset_ctl = watchdog_reset_ctl_r;
    assign irq = irq_r;

endmodule // clock_gate_ctl

// ---- logic/gate_select.sv ----
// Picks the active per-port clock-gating set for the power state.
// Assumes mode and registers come from the same clock domain.
`timescale 1ns/100ps
module gate_select
(
    input wire clkrst_pkg::power_mode_t mode,
    input wire logic auto_clock_gating,
    input wire logic [7:0] run_clock_gate_2,
    input wire logic [7:0] sleep_clock_gate_2,
    input wire logic [7:0] deep_sleep_clock_gate_2,
    output logic [7:0] port_en
);

    logic use_sleep;
    logic use_deep;

    // Without automatic gating the sleep states keep the run set
    assign use_sleep = auto_clock_gating
        && (mode == clkrst_pkg::MODE_SLEEP);
    assign use_deep = auto_clock_gating
        && (mode == clkrst_pkg::MODE_DEEP);
    assign port_en = use_deep ? deep_sleep_clock_gate_2
        : use_sleep ? sleep_clock_gate_2
        : run_clock_gate_2;

endmodule // gate_select

// ---- verification/clock_gate_ctl_monitor.sv ----
// Concurrent checks on the gating and soft-reset block's ports.
// Assumes one aclk domain with synchronous active-low aresetn.
`timescale 1ns/100ps
module clock_gate_ctl_monitor
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [11:0] araddr,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic port_acc_valid,
    input wire logic [2:0] port_acc_sel,
    input wire logic port_acc_fault,
    input wire logic [7:0] port_clk_en,
    input wire logic adc0_reset,
    input wire logic hibernate_reset_ctl,
    input wire logic watchdog_reset_ctl
);
    default clocking dc @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // Read only while no write is in flight; rdata and the outputs load the same register value
    logic rd_srst;
    assign rd_srst = arvalid && arready && awready && wready && !bvalid
        && araddr == clkrst_pkg::OFF_SOFT_RESET;

    AST_RESET_ZERO: assert property ($rose(aresetn) |->
        {port_clk_en, adc0_reset, hibernate_reset_ctl,
        watchdog_reset_ctl} == 11'h000)
        else $error("outputs not zero after reset");
    AST_FAULT: assert property (
        port_acc_valid && !port_clk_en[port_acc_sel] |=> port_acc_fault)
        else $error("gated port access gave no fault");
    AST_NO_FAULT: assert property (
        port_acc_valid && port_clk_en[port_acc_sel] |=> !port_acc_fault)
        else $error("clocked port access faulted");
    AST_DEEP_RSVD: assert property (arvalid && arready &&
        araddr == clkrst_pkg::OFF_DEEP_GATE |=> rvalid && rdata[31:8] == 0)
        else $error("deep gate upper bits not zero");
    AST_SRST_RSVD: assert property (rd_srst |=>
        rvalid && (rdata & ~clkrst_pkg::SRST_MASK) == 32'h0000_0000)
        else $error("soft reset reserved bits not zero");
    AST_SRST_OUT: assert property (rd_srst |=>
        {rdata[16], rdata[6], rdata[3]} == {adc0_reset,
        hibernate_reset_ctl, watchdog_reset_ctl})
        else $error("reset outputs differ from register");
    AST_WRITE_ANSWER: assert property (
        awvalid && awready && wvalid && wready |=> !awready && !wready
        ##1 bvalid)
        else $error("write answer missing");
    AST_BVALID_HOLD: assert property (bvalid && !bready |=>
        bvalid && $stable(bresp))
        else $error("write response dropped early");
    AST_RVALID_HOLD: assert property (rvalid && !rready |=>
        rvalid && $stable(rdata))
        else $error("read data dropped early");
endmodule // clock_gate_ctl_monitor

bind clock_gate_ctl clock_gate_ctl_monitor clock_gate_ctl_monitor_i
(
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rvalid(rvalid), .rready(rready),
    .port_acc_valid(port_acc_valid), .port_acc_sel(port_acc_sel),
    .port_acc_fault(port_acc_fault), .port_clk_en(port_clk_en),
    .adc0_reset(adc0_reset), .hibernate_reset_ctl(hibernate_reset_ctl),
    .watchdog_reset_ctl(watchdog_reset_ctl)
);

// ---- verification/test_clock_gate_ctl.sv ----
// Self-checking bench: register sequences over AXI4-Lite plus port access.
// Assumes the monitor is bound to the design from its own file.
`timescale 1ns/100ps
`define CHECK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
    n_errors++; $display("ERROR %0t got %h exp %h", $time, g, e); end end
module test_clock_gate_ctl;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, irq, port_acc_valid;
    logic port_acc_fault, adc0_reset, hibernate_reset_ctl;
    logic watchdog_reset_ctl;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, capability_mask_1;
    logic [1:0] bresp, rresp;
    logic [2:0] port_acc_sel;
    logic [7:0] port_clk_en;
    clkrst_pkg::power_mode_t power_mode;
    int n_errors = 0;
    int samples_checked = 0;
    int cyc = 0;

    clock_gate_ctl clock_gate_ctl_i
    (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
        .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arprot(3'h0), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .power_mode(power_mode), .capability_mask_1(capability_mask_1),
        .port_acc_valid(port_acc_valid), .port_acc_sel(port_acc_sel),
        .port_acc_fault(port_acc_fault), .port_clk_en(port_clk_en),
        .adc0_reset(adc0_reset), .hibernate_reset_ctl(hibernate_reset_ctl),
        .watchdog_reset_ctl(watchdog_reset_ctl), .irq(irq)
    );

    initial
    begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    task automatic stop_test;
        if (n_errors == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // A hung handshake ends here rather than spinning forever
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            n_errors++;
            stop_test;
        end
    end

    task automatic wr(input logic [11:0] a, input logic [31:0] d,
        input logic [1:0] er = clkrst_pkg::RESP_OKAY);
        logic got;
        got = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!got)
        begin
            @(posedge aclk);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
            if (bvalid && bready)
            begin
                got = 1'b1;
                bready <= 1'b0;
                `CHECK(bresp, er)
            end
            // Late ready lets the hold checks see a waiting answer
            else if (bvalid)
                bready <= 1'b1;
        end
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] ed,
        input logic [1:0] er = clkrst_pkg::RESP_OKAY);
        logic got;
        got = 1'b0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        while (!got)
        begin
            @(posedge aclk);
            if (arvalid && arready)
                arvalid <= 1'b0;
            if (rvalid && rready)
            begin
                got = 1'b1;
                rready <= 1'b0;
                `CHECK(rdata, ed)
                `CHECK(rresp, er)
            end
            else if (rvalid)
                rready <= 1'b1;
        end
    endtask

    task automatic acc(input logic [2:0] s, input logic ef);
        @(posedge aclk);
        port_acc_sel <= s;
        port_acc_valid <= 1'b1;
        @(posedge aclk);
        port_acc_valid <= 1'b0;
        #1;
        `CHECK(port_acc_fault, ef)
    endtask

    task automatic mode(input clkrst_pkg::power_mode_t m, input logic [7:0] e);
        @(posedge aclk);
        power_mode <= m;
        repeat (3) @(posedge aclk);
        #1;
        `CHECK(port_clk_en, e)
    endtask

    task automatic settle(input logic [3:0] e);
        repeat (3) @(posedge aclk);
        #1;
        `CHECK({adc0_reset, hibernate_reset_ctl, watchdog_reset_ctl, irq}, e)
    endtask

    initial
    begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {awaddr, araddr, wdata, port_acc_valid, port_acc_sel} = '0;
        power_mode = clkrst_pkg::MODE_RUN;
        capability_mask_1 = 32'hFFFF_FFFF;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        #1;
        `CHECK(port_clk_en, 8'h00)
        settle(4'h0);
        rd(clkrst_pkg::OFF_SOFT_RESET, 32'h0000_0000);
        rd(clkrst_pkg::OFF_DEEP_GATE, 32'h0000_0000);
        wr(clkrst_pkg::OFF_DEEP_GATE, 32'hFFFF_FFFF);
        rd(clkrst_pkg::OFF_DEEP_GATE, 32'h0000_00FF);
        // Reserved bits written back as they read, zero
        wr(clkrst_pkg::OFF_DEEP_GATE, 32'h0000_00FF & 32'h0000_0004);
        wr(clkrst_pkg::OFF_RUN_GATE, 32'h0000_0001);
        wr(clkrst_pkg::OFF_SLEEP_GATE, 32'h0000_0002);
        mode(clkrst_pkg::MODE_DEEP, 8'h01);
        mode(clkrst_pkg::MODE_SLEEP, 8'h01);
        wr(clkrst_pkg::OFF_RUN_CFG, 32'h0800_0000);
        mode(clkrst_pkg::MODE_DEEP, 8'h04);
        mode(clkrst_pkg::MODE_SLEEP, 8'h02);
        mode(clkrst_pkg::MODE_RUN, 8'h01);
        acc(3'h0, 1'b0);
        acc(3'h7, 1'b1);
        settle(4'h0);
        rd(clkrst_pkg::OFF_INT_STATUS, 32'h0000_0001);
        wr(clkrst_pkg::OFF_INT_MASK, 32'h0000_0001);
        acc(3'h1, 1'b1);
        settle(4'h1);
        rd(clkrst_pkg::OFF_INT_STATUS, 32'h0000_0001);
        // Status is cleared by reading only; writes are ignored
        wr(clkrst_pkg::OFF_INT_STATUS, 32'hFFFF_FFFF);
        rd(clkrst_pkg::OFF_INT_STATUS, 32'h0000_0000);
        settle(4'h0);
        wr(clkrst_pkg::OFF_SOFT_RESET, 32'hFFFF_FFFF);
        rd(clkrst_pkg::OFF_SOFT_RESET, 32'h0001_0048);
        settle(4'hE);
        @(posedge aclk);
        capability_mask_1 <= ~32'h0000_0040;
        wr(clkrst_pkg::OFF_SOFT_RESET, 32'h0001_0048);
        rd(clkrst_pkg::OFF_SOFT_RESET, 32'h0001_0008);
        settle(4'hA);
        rd(clkrst_pkg::OFF_INT_STATUS, 32'h0000_0002);
        wr(clkrst_pkg::OFF_SOFT_RESET, 32'h0000_0000);
        settle(4'h0);
        wr(12'h200, 32'h1234_5678, clkrst_pkg::RESP_SLVERR);
        rd(12'h200, 32'h0000_0000, clkrst_pkg::RESP_SLVERR);
        stop_test;
    end
endmodule // test_clock_gate_ctl
